// [verilog/folr_top.sv]
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Load select and write enable low in parallel mode: each write edge loads empty, full, empty offsets
// - Separate offset write pointer and offset read pointer, advancing independently
// - Master reset puts both offset pointers on the empty offset register
// - Partial reset leaves both offset pointers where they are
// - Load select high sends writes to memory; low again resumes the offset sequence
// - Almost full valid one write edge after its offset is written
// - Almost empty valid five read edges after its offset write, once the offsets have crossed
// - Load select and read enable low: each read edge shows empty, full, empty offsets
// - Readback paused by read enable or load select resumes where it stopped
// - Offset readback overwrites the word on the data output
// - Offset readback works in standard and fall-through modes
// - Retransmit low at a read edge rewinds the read pointer to location zero
// - Standard mode: empty goes low for setup, every later word needs read enable
// - Fall-through: output ready high during setup, first word shown without strobe
// - Almost empty updates on the second read edge after retransmit setup
// - Half full and almost full update together on a write edge once the rewound read pointer crosses
// - Load select at master reset: low gives 127 and parallel, high 1023 and serial
// - Fall-through select at master reset picks standard or fall-through mode
module folr_top (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic rd_clk,
   input wire logic master_rst_n,
   input wire logic partial_rst_n,
   input wire logic load_select_n,
   input wire logic wr_en_n,
   input wire logic [folr_pkg::DATA_W-1:0] data_in,
   input wire logic fall_through_sel,
   input wire logic rd_en_n,
   input wire logic retx_n,
   output logic [folr_pkg::DATA_W-1:0] data_out,
   output logic empty_n,
   output logic out_ready_n,
   output logic almost_empty_n,
   output logic almost_full_n,
   output logic half_full_n,
   output logic fall_through_mode,
   output logic ofs_wr_ptr,
   output logic ofs_rd_ptr
);
   // ======================================
   // Declarations
   localparam int unsigned AW = folr_pkg::ADDR_W;
   localparam int unsigned PW = folr_pkg::PTR_W;
   logic [1:0] wrst_q;
   logic [1:0] rrst_q;
   logic wr_rst_n;
   logic rd_rst_n;
   logic [folr_pkg::SYNC_W_BITS-1:0] sync_w;
   logic [folr_pkg::SYNC_R_BITS-1:0] sync_r;
   logic mrst_w, prst_w, mrst_r, prst_r, ld_r, fall_through_mode_r, xack_w, xreq_r;
   logic [PW-1:0] rgray_w, wgray_r, rptr_w, wptr_r;
   logic par_sel_q, fall_through_mode_q;
   logic [AW-1:0] din_ofs;
   logic [AW-1:0] empty_ofs_q, full_ofs_q, empty_ofs_d, full_ofs_d;
   logic ofs_wptr_q, ofs_wptr_d;
   logic ofs_wr, mem_wr, full_w;
   logic [PW-1:0] wptr_q, wgray_q, words_w, af_thr;
   logic xreq_q, xpend_q, xidle;
   logic [2*AW-1:0] xdata_q;
   logic af_q, hf_q;
   folr_pkg::folr_rd_state_type rd_state_q;
   logic [PW-1:0] rptr_q, rptr_d, rgray_q, words_r, words_rd_d;
   logic [AW-1:0] empty_ofs_r, full_ofs_r;
   logic xack_q, ofs_rptr_q;
   logic ofs_rd, retx_evt, pop_std, take_fall_through_mode, issue_fall_through_mode, issue;
   logic fetch_q, out_valid_q, out_valid_d, ae_calc;
   logic ae_pre_q, ae_q, empty_n_q, out_ready_n_q;
   logic [folr_pkg::DATA_W-1:0] data_out_q;

   folr_mem_if mem_bus ();

   // ======================================
   // Reset release and crossings
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wrst_q <= folr_pkg::RST_SYNC_CLR;
      end else begin
         wrst_q <= {wrst_q[0], 1'b1};
      end
   end

   always_ff @(posedge rd_clk or negedge reset_n) begin
      if (!reset_n) begin
         rrst_q <= folr_pkg::RST_SYNC_CLR;
      end else begin
         rrst_q <= {rrst_q[0], 1'b1};
      end
   end

   assign wr_rst_n = wrst_q[1];
   assign rd_rst_n = rrst_q[1];

   // Async reset pins become synchronous clears per domain
   folr_sync #(.WIDTH(folr_pkg::SYNC_W_BITS)) u_sync_w (
      .clk(mclk),
      .rst_n(wr_rst_n),
      .din({master_rst_n, partial_rst_n, xack_q, rgray_q}),
      .dout(sync_w)
   );

   folr_sync #(.WIDTH(folr_pkg::SYNC_R_BITS)) u_sync_r (
      .clk(rd_clk),
      .rst_n(rd_rst_n),
      .din({master_rst_n, partial_rst_n, load_select_n, fall_through_mode_q, xreq_q, wgray_q}),
      .dout(sync_r)
   );

   assign mrst_w = ~sync_w[PW+2];
   assign prst_w = ~sync_w[PW+1];
   assign xack_w = sync_w[PW];
   assign rgray_w = sync_w[PW-1:0];
   assign rptr_w = folr_pkg::gray2bin(rgray_w);
   assign mrst_r = ~sync_r[PW+4];
   assign prst_r = ~sync_r[PW+3];
   assign ld_r = sync_r[PW+2];
   assign fall_through_mode_r = sync_r[PW+1];
   assign xreq_r = sync_r[PW];
   assign wgray_r = sync_r[PW-1:0];
   assign wptr_r = folr_pkg::gray2bin(wgray_r);

   // ======================================
   // Write side: straps and offset loading
   always_ff @(posedge mclk or negedge wr_rst_n) begin
      if (!wr_rst_n) begin
         par_sel_q <= folr_pkg::PAR_SEL_RST;
         fall_through_mode_q <= folr_pkg::FALL_THROUGH_MODE_RST;
      end else if (mrst_w) begin
         par_sel_q <= ~load_select_n;
         fall_through_mode_q <= fall_through_sel;
      end
   end

   assign din_ofs = data_in[AW-1:0];
   assign ofs_wr = ~wr_en_n & ~load_select_n & par_sel_q;
   assign words_w = wptr_q - rptr_w;
   assign full_w = (words_w == folr_pkg::DEPTH_WORDS);
   assign mem_wr = ~wr_en_n & load_select_n & ~full_w & ~mrst_w & ~prst_w;

   always_comb begin
      empty_ofs_d = empty_ofs_q;
      full_ofs_d = full_ofs_q;
      ofs_wptr_d = ofs_wptr_q;
      if (mrst_w) begin
         empty_ofs_d = load_select_n ? folr_pkg::OFFSET_SER_RST : folr_pkg::OFFSET_PAR_RST;
         full_ofs_d = load_select_n ? folr_pkg::OFFSET_SER_RST : folr_pkg::OFFSET_PAR_RST;
         ofs_wptr_d = folr_pkg::OFS_SEL_EMPTY;
      end else if (ofs_wr) begin
         if (ofs_wptr_q == folr_pkg::OFS_SEL_FULL) begin
            full_ofs_d = din_ofs;
         end else begin
            empty_ofs_d = din_ofs;
         end
         ofs_wptr_d = ~ofs_wptr_q;
      end
   end

   // Partial reset deliberately absent here
   always_ff @(posedge mclk or negedge wr_rst_n) begin
      if (!wr_rst_n) begin
         empty_ofs_q <= folr_pkg::OFFSET_PAR_RST;
         full_ofs_q <= folr_pkg::OFFSET_PAR_RST;
         ofs_wptr_q <= folr_pkg::OFS_SEL_EMPTY;
      end else begin
         empty_ofs_q <= empty_ofs_d;
         full_ofs_q <= full_ofs_d;
         ofs_wptr_q <= ofs_wptr_d;
      end
   end

   // Offsets cross as a held word under a toggle handshake
   assign xidle = (xreq_q == xack_w);

   always_ff @(posedge mclk or negedge wr_rst_n) begin
      if (!wr_rst_n) begin
         xreq_q <= 1'b0;
         xpend_q <= 1'b1;
         xdata_q <= {folr_pkg::OFFSET_PAR_RST, folr_pkg::OFFSET_PAR_RST};
      end else if (xidle && (xpend_q || ofs_wr || mrst_w)) begin
         xdata_q <= {full_ofs_d, empty_ofs_d};
         xreq_q <= ~xreq_q;
         xpend_q <= 1'b0;
      end else if (ofs_wr || mrst_w) begin
         xpend_q <= 1'b1;
      end
   end

   // ======================================
   // Write side: pointer and flags
   always_ff @(posedge mclk or negedge wr_rst_n) begin
      if (!wr_rst_n) begin
         wptr_q <= folr_pkg::PTR_ZERO;
         wgray_q <= folr_pkg::PTR_ZERO;
      end else if (mrst_w || prst_w) begin
         wptr_q <= folr_pkg::PTR_ZERO;
         wgray_q <= folr_pkg::PTR_ZERO;
      end else if (mem_wr) begin
         wptr_q <= wptr_q + folr_pkg::PTR_ONE;
         wgray_q <= folr_pkg::bin2gray(wptr_q + folr_pkg::PTR_ONE);
      end
   end

   assign af_thr = folr_pkg::DEPTH_WORDS - {1'b0, full_ofs_q};

   // Half full comes off the write clock, so it lags a read by the crossing
   always_ff @(posedge mclk or negedge wr_rst_n) begin
      if (!wr_rst_n) begin
         af_q <= folr_pkg::FLAG_HIGH;
         hf_q <= folr_pkg::FLAG_HIGH;
      end else if (mrst_w || prst_w) begin
         af_q <= folr_pkg::FLAG_HIGH;
         hf_q <= folr_pkg::FLAG_HIGH;
      end else begin
         af_q <= (words_w < af_thr);
         hf_q <= (words_w <= folr_pkg::HALF_WORDS);
      end
   end

   assign mem_bus.wr_en = mem_wr;
   assign mem_bus.wr_addr = wptr_q[AW-1:0];
   assign mem_bus.wr_data = data_in;

   // ======================================
   // Read side: offsets received
   always_ff @(posedge rd_clk or negedge rd_rst_n) begin
      if (!rd_rst_n) begin
         empty_ofs_r <= folr_pkg::OFFSET_PAR_RST;
         full_ofs_r <= folr_pkg::OFFSET_PAR_RST;
         xack_q <= 1'b0;
      end else if (xreq_r != xack_q) begin
         empty_ofs_r <= xdata_q[AW-1:0];
         full_ofs_r <= xdata_q[2*AW-1:AW];
         xack_q <= xreq_r;
      end
   end

   // ======================================
   // Read side: next-state decode
   assign words_r = wptr_r - rptr_q;

   always_comb begin
      ofs_rd = ~ld_r & ~rd_en_n;
      retx_evt = (rd_state_q == folr_pkg::RD_RUN) & ~retx_n;
      pop_std = ~fall_through_mode_r & ~rd_en_n & ld_r & (words_r != folr_pkg::PTR_ZERO) & (rd_state_q == folr_pkg::RD_RUN)
                & retx_n;
      take_fall_through_mode = fall_through_mode_r & out_valid_q & ~rd_en_n & ld_r;
      issue_fall_through_mode = fall_through_mode_r & (words_r != folr_pkg::PTR_ZERO) & (rd_state_q == folr_pkg::RD_RUN) & retx_n & ~fetch_q
                   & (~out_valid_q | take_fall_through_mode);
      issue = pop_std | issue_fall_through_mode;
      rptr_d = rptr_q;
      if (retx_evt) begin
         rptr_d = folr_pkg::PTR_ZERO;
      end else if (issue) begin
         rptr_d = rptr_q + folr_pkg::PTR_ONE;
      end
      out_valid_d = out_valid_q;
      if (retx_evt) begin
         out_valid_d = 1'b0;
      end else if (fetch_q) begin
         out_valid_d = 1'b1;
      end else if (take_fall_through_mode) begin
         out_valid_d = 1'b0;
      end
      words_rd_d = wptr_r - rptr_d;
      // Current count, so a rewind shows on the second edge after setup
      ae_calc = (words_r > {1'b0, empty_ofs_r});
   end

   always_ff @(posedge rd_clk or negedge rd_rst_n) begin
      if (!rd_rst_n) begin
         rd_state_q <= folr_pkg::RD_RUN;
      end else if (mrst_r || prst_r) begin
         rd_state_q <= folr_pkg::RD_RUN;
      end else begin
         case (rd_state_q)
            folr_pkg::RD_RUN: begin
               if (retx_evt) begin
                  rd_state_q <= folr_pkg::RD_SETUP;
               end
            end
            default: begin
               rd_state_q <= folr_pkg::RD_RUN;
            end
         endcase
      end
   end

   // ======================================
   // Read side: pointers and data
   always_ff @(posedge rd_clk or negedge rd_rst_n) begin
      if (!rd_rst_n) begin
         rptr_q <= folr_pkg::PTR_ZERO;
         rgray_q <= folr_pkg::PTR_ZERO;
         fetch_q <= 1'b0;
         out_valid_q <= 1'b0;
      end else if (mrst_r || prst_r) begin
         rptr_q <= folr_pkg::PTR_ZERO;
         rgray_q <= folr_pkg::PTR_ZERO;
         fetch_q <= 1'b0;
         out_valid_q <= 1'b0;
      end else begin
         rptr_q <= rptr_d;
         rgray_q <= folr_pkg::bin2gray(rptr_d);
         fetch_q <= issue;
         out_valid_q <= out_valid_d;
      end
   end

   // Readback pointer held by master reset only
   always_ff @(posedge rd_clk or negedge rd_rst_n) begin
      if (!rd_rst_n) begin
         ofs_rptr_q <= folr_pkg::OFS_SEL_EMPTY;
      end else if (mrst_r) begin
         ofs_rptr_q <= folr_pkg::OFS_SEL_EMPTY;
      end else if (ofs_rd) begin
         ofs_rptr_q <= ~ofs_rptr_q;
      end
   end

   // Readback wins over a fetch landing in the same cycle
   always_ff @(posedge rd_clk or negedge rd_rst_n) begin
      if (!rd_rst_n) begin
         data_out_q <= folr_pkg::DATA_RST;
      end else if (mrst_r || prst_r) begin
         data_out_q <= folr_pkg::DATA_RST;
      end else if (ofs_rd) begin
         data_out_q <= {{(folr_pkg::DATA_W - AW){1'b0}},
                        (ofs_rptr_q == folr_pkg::OFS_SEL_FULL) ? full_ofs_r : empty_ofs_r};
      end else if (fetch_q) begin
         data_out_q <= mem_bus.rd_data;
      end
   end

   always_ff @(posedge rd_clk or negedge rd_rst_n) begin
      if (!rd_rst_n) begin
         empty_n_q <= folr_pkg::FLAG_LOW;
         out_ready_n_q <= folr_pkg::FLAG_HIGH;
         ae_pre_q <= folr_pkg::FLAG_LOW;
         ae_q <= folr_pkg::FLAG_LOW;
      end else if (mrst_r || prst_r) begin
         empty_n_q <= folr_pkg::FLAG_LOW;
         out_ready_n_q <= folr_pkg::FLAG_HIGH;
         ae_pre_q <= folr_pkg::FLAG_LOW;
         ae_q <= folr_pkg::FLAG_LOW;
      end else begin
         empty_n_q <= fall_through_mode_r | (~retx_evt & (words_rd_d != folr_pkg::PTR_ZERO));
         out_ready_n_q <= ~fall_through_mode_r | ~out_valid_d;
         ae_pre_q <= ae_calc;
         ae_q <= ae_pre_q;
      end
   end

   assign mem_bus.rd_en = issue;
   assign mem_bus.rd_addr = rptr_q[AW-1:0];

   folr_mem u_mem (
      .wr_clk(mclk),
      .rd_clk(rd_clk),
      .mem(mem_bus)
   );

   assign data_out = data_out_q;
   assign empty_n = empty_n_q;
   assign out_ready_n = out_ready_n_q;
   assign almost_empty_n = ae_q;
   assign almost_full_n = af_q;
   assign half_full_n = hf_q;
   assign fall_through_mode = fall_through_mode_q;
   assign ofs_wr_ptr = ofs_wptr_q;
   assign ofs_rd_ptr = ofs_rptr_q;

   // ======================================
   // Assertions
   AST_OFS_WR_DATA: assert property (@(posedge mclk) disable iff (!wr_rst_n)
      ofs_wr && !mrst_w && ofs_wptr_q == folr_pkg::OFS_SEL_EMPTY |=> empty_ofs_q == $past(din_ofs)
                                                                     && ofs_wptr_q == folr_pkg::OFS_SEL_FULL)
      else $error("empty offset not loaded");
   AST_OFS_WR_SEQ: assert property (@(posedge mclk) disable iff (!wr_rst_n)
      ofs_wr && !mrst_w && ofs_wptr_q == folr_pkg::OFS_SEL_FULL |=> full_ofs_q == $past(din_ofs)
                                                                    && $stable(empty_ofs_q))
      else $error("full offset not loaded");
   AST_MRST_PTR: assert property (@(posedge mclk) disable iff (!wr_rst_n)
      mrst_w |=> ofs_wptr_q == folr_pkg::OFS_SEL_EMPTY)
      else $error("master reset left offset pointer");
   AST_PRST_KEEP: assert property (@(posedge mclk) disable iff (!wr_rst_n)
      prst_w && !mrst_w && !ofs_wr |=> $stable(ofs_wptr_q) && $stable(full_ofs_q))
      else $error("partial reset moved offsets");
   AST_MEM_WR: assert property (@(posedge mclk) disable iff (!wr_rst_n)
      load_select_n && !wr_en_n && !full_w && !mrst_w && !prst_w
      |=> wptr_q == $past(wptr_q) + folr_pkg::PTR_ONE && $stable(empty_ofs_q) && $stable(full_ofs_q))
      else $error("memory write misrouted");
   AST_AF_FLAG: assert property (@(posedge mclk) disable iff (!wr_rst_n)
      !mrst_w && !prst_w |=> almost_full_n == ($past(words_w) < $past(af_thr)))
      else $error("almost full wrong");
   AST_OFS_RD: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
      ofs_rd && !mrst_r && !prst_r
      |=> data_out[AW-1:0] == ($past(ofs_rptr_q) ? $past(full_ofs_r) : $past(empty_ofs_r)))
      else $error("offset readback wrong");
   AST_OFS_RD_HOLD: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
      !ofs_rd && !mrst_r |=> $stable(ofs_rptr_q))
      else $error("readback pointer moved");
   AST_RETX_PTR: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
      retx_evt && !mrst_r && !prst_r |=> rptr_q == folr_pkg::PTR_ZERO ##1 rd_state_q == folr_pkg::RD_RUN)
      else $error("retransmit rewind wrong");
   AST_RETX_EMPTY: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
      retx_evt && !fall_through_mode_r && !mrst_r && !prst_r |=> !empty_n)
      else $error("empty not low in setup");
   AST_RETX_OR: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
      retx_evt && fall_through_mode_r && !mrst_r && !prst_r |=> out_ready_n [*2])
      else $error("output ready not high in setup");
   AST_AE_LAG: assert property (@(posedge rd_clk) disable iff (!rd_rst_n)
      !mrst_r && !prst_r ##1 !mrst_r && !prst_r |=> almost_empty_n == $past(ae_calc, 2))
      else $error("almost empty lag wrong");

   COV_OFS_FULL_WR: cover property (@(posedge mclk) disable iff (!wr_rst_n)
      ofs_wr && ofs_wptr_q == folr_pkg::OFS_SEL_FULL);
   COV_OFS_FULL_RD: cover property (@(posedge rd_clk) disable iff (!rd_rst_n)
      ofs_rd && ofs_rptr_q == folr_pkg::OFS_SEL_FULL);
   COV_RETX_STD: cover property (@(posedge rd_clk) disable iff (!rd_rst_n)
      retx_evt && !fall_through_mode_r ##2 empty_n);
   COV_RETX_FALL_THROUGH_MODE: cover property (@(posedge rd_clk) disable iff (!rd_rst_n)
      retx_evt && fall_through_mode_r ##[1:6] !out_ready_n);
endmodule
`default_nettype wire

// [verilog/folr_pkg.sv]
package folr_pkg;
   // ======================================
   // Widths and depth
   localparam int unsigned DATA_W = 18;
   localparam int unsigned ADDR_W = 15;
   localparam int unsigned PTR_W = 16;
   localparam int unsigned DEPTH = 32768;
   localparam int unsigned SYNC_W_BITS = 19;
   localparam int unsigned SYNC_R_BITS = 21;
   localparam logic [PTR_W-1:0] DEPTH_WORDS = 16'h8000;
   localparam logic [PTR_W-1:0] HALF_WORDS = 16'h4000;
   localparam logic [PTR_W-1:0] PTR_ZERO = 16'h0000;
   localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;

   // ======================================
   // Reset values
   localparam logic [ADDR_W-1:0] OFFSET_PAR_RST = 15'h007F;
   localparam logic [ADDR_W-1:0] OFFSET_SER_RST = 15'h03FF;
   localparam logic [DATA_W-1:0] DATA_RST = 18'h0_0000;
   localparam logic [1:0] RST_SYNC_CLR = 2'h0;
   localparam logic PAR_SEL_RST = 1'b1;
   localparam logic FALL_THROUGH_MODE_RST = 1'b0;
   localparam logic FLAG_LOW = 1'b0;
   localparam logic FLAG_HIGH = 1'b1;

   // ======================================
   // Offset register selectors
   localparam logic OFS_SEL_EMPTY = 1'b0;
   localparam logic OFS_SEL_FULL = 1'b1;

   typedef enum logic [0:0] {
      RD_RUN,
      RD_SETUP
   } folr_rd_state_type;

   // ======================================
   // Gray code helpers
   function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b = g;
      for (int i = PTR_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction
endpackage

// [verilog/folr_mem_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface folr_mem_if;
   logic wr_en;
   logic [folr_pkg::ADDR_W-1:0] wr_addr;
   logic [folr_pkg::DATA_W-1:0] wr_data;
   logic rd_en;
   logic [folr_pkg::ADDR_W-1:0] rd_addr;
   logic [folr_pkg::DATA_W-1:0] rd_data;

   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
   modport ram (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// [verilog/folr_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module folr_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   // ======================================
   // Two stages; first stage feeds only the second
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule
`default_nettype wire

// [verilog/folr_mem.sv]
`timescale 1ns/100ps
`default_nettype none
module folr_mem (
   input wire logic wr_clk,
   input wire logic rd_clk,
   folr_mem_if.ram mem
);
   // ======================================
   // Storage, no reset on data
   logic [folr_pkg::DATA_W-1:0] store_q [folr_pkg::DEPTH];
   logic [folr_pkg::DATA_W-1:0] rd_data_q;

   always_ff @(posedge wr_clk) begin
      if (mem.wr_en) begin
         store_q[mem.wr_addr] <= mem.wr_data;
      end
   end

   always_ff @(posedge rd_clk) begin
      if (mem.rd_en) begin
         rd_data_q <= store_q[mem.rd_addr];
      end
   end

   assign mem.rd_data = rd_data_q;
endmodule
`default_nettype wire

// [bench/folr_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ======================================
// Controller model on both strobe sides
module folr_ctrl_model (
   input wire logic mclk,
   input wire logic rd_clk,
   output logic load_select_n,
   output logic wr_en_n,
   output logic [folr_pkg::DATA_W-1:0] data_in,
   output logic rd_en_n,
   output logic retx_n
);
   initial begin
      load_select_n = 1'b0;
      wr_en_n = 1'b1;
      data_in = 18'h0_0000;
      rd_en_n = 1'b1;
      retx_n = 1'b1;
   end
   // Sequenced calls, so reads and writes never overlap
   task automatic wr_word(input logic ls, input logic [17:0] d);
      @(negedge mclk);
      load_select_n = ls;
      wr_en_n = 1'b0;
      data_in = d;
      @(negedge mclk);
      wr_en_n = 1'b1;
      data_in = ~d; // No stale word left after the strobe
   endtask
   task automatic set_ls(input logic v);
      @(negedge mclk);
      load_select_n = v;
   endtask
   task automatic rd_pulse();
      @(negedge rd_clk);
      rd_en_n = 1'b0;
      @(negedge rd_clk);
      rd_en_n = 1'b1;
   endtask
   // Both enables already high here
   task automatic retx();
      @(negedge rd_clk);
      retx_n = 1'b0;
      @(negedge rd_clk);
      retx_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// [bench/tb_folr_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_folr_top;
   logic mclk, rd_clk, reset_n, master_rst_n, partial_rst_n, fall_through_sel;
   logic load_select_n, wr_en_n, rd_en_n, retx_n, ready_flag;
   logic empty_n, out_ready_n, almost_empty_n, almost_full_n, half_full_n, fall_through_mode;
   logic ofs_wr_ptr, ofs_rd_ptr;
   logic [17:0] data_in, data_out, e1, f, e2, w0;
   int miscompares = 0;
   int checks_done = 0;
   assign ready_flag = fall_through_mode ? ~out_ready_n : empty_n;
   // ======================================
   // Clocks, unrelated in phase
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      rd_clk = 1'b0;
      #1.3;
      forever #3 rd_clk = ~rd_clk;
   end
   folr_top i_folr_top (.mclk, .reset_n, .rd_clk, .master_rst_n, .partial_rst_n, .load_select_n, .wr_en_n,
      .data_in, .fall_through_sel, .rd_en_n, .retx_n, .data_out, .empty_n, .out_ready_n, .almost_empty_n,
      .almost_full_n, .half_full_n, .fall_through_mode, .ofs_wr_ptr, .ofs_rd_ptr);
   folr_ctrl_model i_folr_ctrl_model (.mclk, .rd_clk, .load_select_n, .wr_en_n, .data_in, .rd_en_n, .retx_n);
   // ======================================
   // Checking and expectations
   task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   function automatic logic [17:0] ae(input int words, input logic [17:0] n);
      return (words <= int'(n[14:0])) ? 18'h0_0000 : 18'h0_0001;
   endfunction
   function automatic logic [17:0] af(input int words, input logic [17:0] m);
      return (words >= 32768 - int'(m[14:0])) ? 18'h0_0000 : 18'h0_0001;
   endfunction
   task automatic rd_wait(input int n);
      repeat (n) @(negedge rd_clk);
   endtask
   task automatic mreset(input logic mode, input logic ls);
      i_folr_ctrl_model.set_ls(ls);
      master_rst_n = 1'b0;
      fall_through_sel = mode;
      repeat (8) @(negedge mclk);
      master_rst_n = 1'b1;
      rd_wait(6);
   endtask
   task automatic rdback(input logic [17:0] exp);
      i_folr_ctrl_model.rd_pulse();
      rd_wait(1);
      chk("data_out", exp, data_out);
   endtask
   // Long enough for several passes of the sequence
   initial begin
      #300000;
      miscompares++;
      finish_test();
   end
   // ======================================
   // Main sequence, standard mode then fall-through
   initial begin
      reset_n = 1'b0;
      master_rst_n = 1'b0;
      partial_rst_n = 1'b1;
      fall_through_sel = 1'b0;
      void'($urandom(30));
      repeat (6) @(negedge mclk);
      reset_n = 1'b1;
      for (int m = 0; m < 2; m++) begin
         mreset(m[0], 1'b0);
         chk("fall_through_mode", 18'(m), 18'(fall_through_mode));
         chk("ofs_ptrs", 18'h0_0000, 18'({ofs_wr_ptr, ofs_rd_ptr}));
         rdback(18'h0_007F);
         rdback(18'h0_007F);
         e1 = 18'($urandom);
         f = {3'($urandom), 15'($urandom_range(32763, 32767))};
         // Corner: offset 3 makes the rewind from three to four words flip the flag
         e2 = {3'($urandom), 15'((m == 0) ? 3 : $urandom_range(2, 5))};
         w0 = 18'($urandom);
         i_folr_ctrl_model.wr_word(1'b0, e1);
         @(negedge mclk);
         chk("ofs_wr_ptr", 18'h0_0001, 18'(ofs_wr_ptr));
         partial_rst_n = 1'b0;
         repeat (8) @(negedge mclk);
         partial_rst_n = 1'b1;
         rd_wait(6);
         chk("ofs_wr_ptr", 18'h0_0001, 18'(ofs_wr_ptr));
         i_folr_ctrl_model.wr_word(1'b0, f);
         for (int i = 0; i < 4; i++) begin
            i_folr_ctrl_model.wr_word(1'b1, (i == 0) ? w0 : 18'($urandom));
         end
         rd_wait(10);
         i_folr_ctrl_model.wr_word(1'b0, e2);
         @(negedge mclk);
         chk("ofs_wr_ptr", 18'h0_0001, 18'(ofs_wr_ptr));
         rd_wait(12);
         chk("almost_empty_n", ae(4 - m, e2), 18'(almost_empty_n));
         chk("almost_full_n", af(4 - m, f), 18'(almost_full_n));
         chk("half_full_n", 18'h0_0001, 18'(half_full_n));
         rdback({3'h0, e2[14:0]});
         rd_wait(3);
         rdback({3'h0, f[14:0]});
         rdback({3'h0, e2[14:0]});
         i_folr_ctrl_model.set_ls(1'b1);
         rd_wait(4);
         if (m == 0) begin
            i_folr_ctrl_model.rd_pulse();
            rd_wait(3);
            chk("data_out", w0, data_out);
         end
         i_folr_ctrl_model.retx();
         chk("setup flag", 18'h0_0000, 18'(ready_flag));
         rd_wait(1);
         if (m == 0) begin
            chk("almost_empty_n", ae(3, e2), 18'(almost_empty_n));
         end
         rd_wait(1);
         if (m == 0) begin
            chk("almost_empty_n", ae(4, e2), 18'(almost_empty_n));
         end
         for (int i = 0; i < 10 && ready_flag !== 1'b1; i++) begin
            rd_wait(1);
         end
         chk("ready flag", 18'h0_0001, 18'(ready_flag));
         if (m == 0) begin
            i_folr_ctrl_model.rd_pulse();
            rd_wait(3);
         end
         chk("data_out", w0, data_out);
      end
      // Serial method strapped: parallel loads refused, defaults read back
      mreset(1'b1, 1'b1);
      i_folr_ctrl_model.wr_word(1'b0, e1);
      rd_wait(12);
      chk("ofs_wr_ptr", 18'h0_0000, 18'(ofs_wr_ptr));
      rdback(18'h0_03FF);
      rdback(18'h0_03FF);
      finish_test();
   end
endmodule
`default_nettype wire
